/* conv_pkg.sv */
package conv_pkg;
    // result coding
    localparam int CODE_W = 10;
    localparam logic [9:0] SE_MIN_CODE = 10'h000;
    localparam logic [9:0] SE_MAX_CODE = 10'h3ff;
    localparam logic [9:0] DIFF_MAX_CODE = 10'h1ff;
    localparam logic [9:0] DIFF_MIN_CODE = 10'h200;
    localparam logic signed [15:0] SE_LIMIT = 16'sh03ff;
    localparam logic signed [24:0] DIFF_HI = 25'sh00001ff;
    localparam logic signed [24:0] DIFF_LO = -25'sh0000200;
    localparam logic signed [8:0] GAIN_1_VAL = 9'sh001;
    localparam logic signed [8:0] GAIN_10_VAL = 9'sh00a;
    localparam logic signed [8:0] GAIN_200_VAL = 9'sh0c8;
    // result byte layout
    localparam int BYTE_W = 8;
    localparam int LEFT_PAD = 6;
    // reference select encodings
    localparam logic [1:0] REF_EXTERNAL = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_RESERVED = 2'h2;
    localparam logic [1:0] REF_INTERNAL = 2'h3;
    localparam logic [1:0] REF_RESET = 2'h0;
    // channel select encodings
    localparam logic [4:0] SEL_BANDGAP = 5'h1e;
    localparam logic [4:0] SEL_GROUND = 5'h1f;
    localparam logic [4:0] SEL_RESET = 5'h00;
    localparam logic [1:0] SEL_SE_GROUP = 2'h0;
    localparam logic [1:0] SEL_GAIN_GROUP = 2'h1;
    localparam int SEL_GAIN_BIT = 1;
    // timing
    localparam int CORE_CLK_KHZ = 250000;
    localparam int CONV_CLK_KHZ = 1000;
    localparam int PRESCALE = CORE_CLK_KHZ / CONV_CLK_KHZ;
    localparam int PRESCALE_W = 8;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(PRESCALE - 1);
    localparam int CONV_TICKS = 13;
    localparam int FIRST_TICKS = 25;
    localparam logic [4:0] CONV_LAST = 5'(CONV_TICKS - 1);
    localparam logic [4:0] FIRST_LAST = 5'(FIRST_TICKS - 1);

    typedef enum logic [1:0] {GAIN_1, GAIN_10, GAIN_200} gain_e;
    typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_CONV} state_e;
endpackage

/* coder_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface coder_if;
    import conv_pkg::*;
    logic signed [15:0] level;
    logic is_diff;
    gain_e gain;
    logic [CODE_W-1:0] code;
    modport ctrl (output level, output is_diff, output gain, input code);
    modport coder (input level, input is_diff, input gain, output code);
endinterface
`default_nettype wire

/* result_coder.sv */
`timescale 1ns/1ps
`default_nettype none
module result_coder import conv_pkg::*; (
    coder_if.coder bus
);
    wire signed [8:0] gain_val;
    wire signed [24:0] prod;
    wire diff_hi;
    wire diff_lo;
    wire [CODE_W-1:0] diff_code;
    wire se_lo;
    wire se_hi;
    wire [CODE_W-1:0] se_code;

    assign gain_val = (bus.gain == GAIN_200) ? GAIN_200_VAL :
                      (bus.gain == GAIN_10) ? GAIN_10_VAL : GAIN_1_VAL;
    // level is difference in steps of reference/512; scale by gain
    assign prod = 25'(bus.level) * 25'(gain_val);
    assign diff_hi = prod > DIFF_HI;
    assign diff_lo = prod < DIFF_LO;
    // two's complement, low ten bits carry the sign in bit 9
    assign diff_code = diff_hi ? DIFF_MAX_CODE :
                       diff_lo ? DIFF_MIN_CODE : prod[CODE_W-1:0];
    // level is input in steps of reference/1024
    assign se_lo = bus.level[15];
    assign se_hi = bus.level > SE_LIMIT;
    assign se_code = se_lo ? SE_MIN_CODE :
                     se_hi ? SE_MAX_CODE : bus.level[CODE_W-1:0];
    assign bus.code = bus.is_diff ? diff_code : se_code;
endmodule
`default_nettype wire

/* adc_result_and_sleep_conversion.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_result_and_sleep_conversion import conv_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_converter_enable_bit,
    input wire logic i_start,
    input wire logic i_free_run,
    input wire logic i_irq_enable,
    input wire logic i_done_clear,
    input wire logic i_left_adjust_bit,
    input wire logic [1:0] i_reference_select,
    input wire logic [4:0] i_channel_select,
    input wire logic i_sleep_idle,
    input wire logic i_sleep_noise_reduction,
    input wire logic i_core_halted,
    input wire logic signed [15:0] i_level,
    output logic o_busy,
    output logic o_conversion_done_flag,
    output logic o_irq,
    output logic [7:0] o_result_low_byte,
    output logic [7:0] o_result_high_byte,
    output logic o_result_sign_bit,
    output logic o_converter_power,
    output logic o_ref_external,
    output logic o_ref_supply,
    output logic o_ref_internal,
    output logic [4:0] o_channel_sel
);
    state_e state_r, state_nxt;
    logic [PRESCALE_W-1:0] pre_cnt_r;
    logic [4:0] tick_cnt_r;
    logic first_r;
    logic halt_d_r;
    logic [1:0] ref_r;
    logic [4:0] sel_r;
    logic done_r;
    logic [CODE_W-1:0] result_r;
    wire tick;
    wire [4:0] last_tick;
    wire finish;
    wire halt_rise;
    wire sleep_ok;
    wire start;
    wire restart;
    wire load_sel;
    wire is_diff;
    wire done_nxt;
    wire [CODE_W-1:0] result_nxt;
    wire [7:0] low_nxt;
    wire [7:0] high_nxt;

    coder_if cbus ();
    result_coder i_result_coder (
        .bus(cbus.coder)
    );

    // prescaled converter clock, one-cycle enable
    assign tick = pre_cnt_r == PRESCALE_LAST;
    assign last_tick = first_r ? FIRST_LAST : CONV_LAST;
    assign finish = (state_r == ST_CONV) && tick && (tick_cnt_r == last_tick);

    // sleep start only once software has set up enable, single mode and interrupt
    assign halt_rise = i_core_halted & ~halt_d_r;
    assign sleep_ok = (i_sleep_idle | i_sleep_noise_reduction) & halt_rise
                      & ~i_free_run & i_irq_enable;
    assign start = (state_r == ST_IDLE) && i_converter_enable_bit && (i_start || sleep_ok);
    assign restart = finish && i_free_run && i_converter_enable_bit;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OFF: begin
                if (i_converter_enable_bit) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (!i_converter_enable_bit) begin
                    state_nxt = ST_OFF;
                end else if (start) begin
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                // a wake from elsewhere does not stop the conversion
                if (!i_converter_enable_bit) begin
                    state_nxt = ST_OFF;
                end else if (finish && !restart) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset || state_r != ST_CONV || tick) begin
            pre_cnt_r <= '0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset || state_r != ST_CONV || finish) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
        end
    end

    // extended first conversion after each enable
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            first_r <= 1'b0;
        end else if (state_r == ST_OFF && i_converter_enable_bit) begin
            first_r <= 1'b1;
        end else if (finish) begin
            first_r <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            halt_d_r <= 1'b0;
        end else begin
            halt_d_r <= i_core_halted;
        end
    end

    // settings track freely until a start, then locked until completion
    assign load_sel = (state_r != ST_CONV) || finish;
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            ref_r <= REF_RESET;
            sel_r <= SEL_RESET;
        end else if (load_sel) begin
            ref_r <= i_reference_select;
            sel_r <= i_channel_select;
        end
    end

    // equal positive and negative inputs are legal selections
    assign is_diff = (sel_r[4:3] != SEL_SE_GROUP) && (sel_r != SEL_BANDGAP)
                     && (sel_r != SEL_GROUND);
    assign cbus.level = i_level;
    assign cbus.is_diff = is_diff;
    assign cbus.gain = (sel_r[4:3] != SEL_GAIN_GROUP) ? GAIN_1 :
                       sel_r[SEL_GAIN_BIT] ? GAIN_200 : GAIN_10;

    // set wins over a clear in the same cycle
    assign done_nxt = finish | (done_r & ~i_done_clear);
    assign result_nxt = finish ? cbus.code : result_r;
    // bytes follow the adjust bit one clock later, even with no new result
    assign high_nxt = i_left_adjust_bit ? result_nxt[CODE_W-1:2] :
                      {{LEFT_PAD{1'b0}}, result_nxt[CODE_W-1:BYTE_W]};
    assign low_nxt = i_left_adjust_bit ? {result_nxt[1:0], {LEFT_PAD{1'b0}}} :
                     result_nxt[BYTE_W-1:0];

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            done_r <= 1'b0;
            result_r <= '0;
        end else begin
            done_r <= done_nxt;
            result_r <= result_nxt;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_result_low_byte <= '0;
            o_result_high_byte <= '0;
            o_result_sign_bit <= 1'b0;
        end else begin
            o_result_low_byte <= low_nxt;
            o_result_high_byte <= high_nxt;
            o_result_sign_bit <= result_nxt[CODE_W-1];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_busy <= 1'b0;
            o_conversion_done_flag <= 1'b0;
            o_irq <= 1'b0;
            o_converter_power <= 1'b0;
            o_ref_external <= 1'b0;
            o_ref_supply <= 1'b0;
            o_ref_internal <= 1'b0;
            o_channel_sel <= SEL_RESET;
        end else begin
            o_busy <= state_nxt == ST_CONV;
            o_conversion_done_flag <= done_nxt;
            // request stands whether or not the core is already awake
            o_irq <= done_nxt & i_irq_enable;
            // sleep mode has no say in power; only the enable bit does
            o_converter_power <= i_converter_enable_bit;
            // reserved code selects no source
            o_ref_external <= ref_r == REF_EXTERNAL;
            o_ref_supply <= ref_r == REF_SUPPLY;
            o_ref_internal <= ref_r == REF_INTERNAL;
            o_channel_sel <= sel_r;
        end
    end

    default clocking dcb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    property p_done_result;
        finish |=> o_conversion_done_flag && (result_r == $past(cbus.code));
    endproperty
    a_done_result: assert property (p_done_result) else $error("result and flag not together");
    property p_hold;
        o_conversion_done_flag && !finish && !i_done_clear
            |=> o_conversion_done_flag && $stable(result_r);
    endproperty
    a_hold: assert property (p_hold) else $error("held result changed");
    property p_sleep_start;
        state_r == ST_IDLE && i_converter_enable_bit && sleep_ok |=> o_busy ##1 o_busy;
    endproperty
    a_sleep_start: assert property (p_sleep_start) else $error("sleep start missed");
    property p_irq;
        finish && i_irq_enable |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("no completion request");
    property p_continue;
        state_r == ST_CONV && !finish && i_converter_enable_bit && $fell(i_core_halted)
            |=> state_r == ST_CONV;
    endproperty
    a_continue: assert property (p_continue) else $error("wake stopped conversion");
    property p_lock;
        state_r == ST_CONV && !finish |=> $stable(sel_r) && $stable(ref_r);
    endproperty
    a_lock: assert property (p_lock) else $error("settings changed in conversion");
    property p_se_clamp;
        finish && !is_diff && (i_level > SE_LIMIT) |=> result_r == SE_MAX_CODE;
    endproperty
    a_se_clamp: assert property (p_se_clamp) else $error("single-ended wrap");
    property p_diff_clamp;
        finish && is_diff && (i_level >= 16'sh0200) |=> result_r == DIFF_MAX_CODE;
    endproperty
    a_diff_clamp: assert property (p_diff_clamp) else $error("differential overflow");
    property p_left;
        i_left_adjust_bit |=> o_result_low_byte[5:0] == 6'h00
            && o_result_high_byte == result_r[CODE_W-1:2];
    endproperty
    a_left: assert property (p_left) else $error("left adjust wrong");
    property p_power;
        i_converter_enable_bit && !i_sleep_idle && !i_sleep_noise_reduction ##1 i_core_halted
            |-> o_converter_power;
    endproperty
    a_power: assert property (p_power) else $error("power dropped in sleep");
    property p_ref;
        ref_r == REF_INTERNAL |=> o_ref_internal && !o_ref_external && !o_ref_supply;
    endproperty
    a_ref: assert property (p_ref) else $error("reference decode wrong");

    c_sleep: cover property (sleep_ok && start);
    c_free_run: cover property (restart);
    c_clear_race: cover property (finish && i_done_clear);
    c_negative: cover property (finish && is_diff && cbus.code[CODE_W-1]);
endmodule
`default_nettype wire

/* adc_result_and_sleep_conversion_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_result_and_sleep_conversion_tb;
    import conv_pkg::*;
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, start = 1'b0, free_run = 1'b0, irq_en = 1'b0;
    logic done_clr = 1'b0, left = 1'b0, sl_idle = 1'b0, sl_nr = 1'b0, halted = 1'b0;
    logic [1:0] ref_sel = 2'h0;
    logic [4:0] chan = 5'h00;
    logic signed [15:0] level = 16'sh0000;
    logic busy, done, irq, sign, power, r_ext, r_sup, r_int;
    logic [7:0] lo, hi;
    logic [4:0] chan_out;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    // single-ended rows first, then differential; codes from input*gain, clamped
    logic [4:0] t_chan [8] = '{5'h02, 5'h03, 5'h1f, 5'h0d, 5'h0b, 5'h08, 5'h10, 5'h0f};
    logic signed [15:0] t_lvl [8] = '{16'sh0155, 16'sh07d0, -16'sh0005, -16'sh0028,
        16'sh0003, 16'sh0000, -16'sh0001, -16'sh0003};
    logic [9:0] t_code [8] = '{10'h155, 10'h3ff, 10'h000, 10'h270, 10'h1ff, 10'h000,
        10'h3ff, 10'h200};

    always #2 clk = ~clk;

    adc_result_and_sleep_conversion i_adc_result_and_sleep_conversion (
        .i_core_clk(clk), .i_reset(rst), .i_converter_enable_bit(en), .i_start(start),
        .i_free_run(free_run), .i_irq_enable(irq_en), .i_done_clear(done_clr),
        .i_left_adjust_bit(left), .i_reference_select(ref_sel), .i_channel_select(chan),
        .i_sleep_idle(sl_idle), .i_sleep_noise_reduction(sl_nr), .i_core_halted(halted),
        .i_level(level), .o_busy(busy), .o_conversion_done_flag(done), .o_irq(irq),
        .o_result_low_byte(lo), .o_result_high_byte(hi), .o_result_sign_bit(sign),
        .o_converter_power(power), .o_ref_external(r_ext), .o_ref_supply(r_sup),
        .o_ref_internal(r_int), .o_channel_sel(chan_out)
    );

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check_flag(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_val(input string what, input logic [9:0] exp, input logic [9:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_res(input logic [9:0] code);
        check_val("high byte", left ? {2'h0, code[9:2]} : {8'h00, code[9:8]}, {2'h0, hi});
        check_val("low byte", left ? {2'h0, code[1:0], 6'h00} : {2'h0, code[7:0]}, {2'h0, lo});
        check_flag("sign", code[9], sign);
    endtask

    // waits out a conversion; bound covers the long first conversion
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy === 1'b1 && n < 7000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check_flag("done", 1'b1, done);
        check_flag("irq", irq_en, irq);
    endtask

    task automatic clear_done();
        @(posedge clk);
        done_clr <= 1'b1;
        @(posedge clk);
        done_clr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check_flag("done cleared", 1'b0, done);
        check_flag("irq cleared", 1'b0, irq);
    endtask

    task automatic convert(input logic [4:0] c, input logic signed [15:0] lv,
        input logic [9:0] code);
        @(posedge clk);
        chan <= c;
        level <= lv;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        #1;
        check_flag("busy", 1'b1, busy);
        wait_idle();
        check_res(code);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles >= 70000) begin
            err_count++;
            $display("BAD timeout expected finish seen hang");
            stop_test();
        end
    end

    initial begin
        repeat (11) @(posedge clk);
        #1;
        check_flag("reset busy", 1'b0, busy);
        check_flag("reset power", 1'b0, power);
        check_val("reset high", 10'h000, {2'h0, hi});
        @(posedge clk);
        rst <= 1'b0;
        en <= 1'b1;
        irq_en <= 1'b1;
        repeat (3) @(posedge clk);
        $display("test reset done");

        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            ref_sel <= 2'(r);
            repeat (2) @(posedge clk);
            #1;
            check_flag("ref external", r == 0, r_ext);
            check_flag("ref supply", r == 1, r_sup);
            check_flag("ref internal", r == 3, r_int);
        end
        $display("test reference done");

        for (int i = 0; i < 8; i++) begin
            left <= (i == 3);
            convert(t_chan[i], t_lvl[i], t_code[i]);
            if (i == 3) begin
                left <= 1'b0;
                repeat (2) @(posedge clk);
                #1;
                check_res(t_code[i]);
            end
            clear_done();
        end
        $display("test coding done");

        // second pass drops halted mid-run, as if another wake came first
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            chan <= 5'h01;
            level <= 16'sh00aa;
            sl_nr <= (m == 0);
            sl_idle <= (m == 1);
            @(posedge clk);
            halted <= 1'b1;
            repeat (3) @(posedge clk);
            #1;
            check_flag("sleep busy", 1'b1, busy);
            @(posedge clk);
            chan <= 5'h1f;
            if (m == 1) begin
                halted <= 1'b0;
            end
            repeat (20) @(posedge clk);
            #1;
            check_val("locked chan", 10'h001, {5'h00, chan_out});
            check_flag("busy on", 1'b1, busy);
            wait_idle();
            check_res(10'h0aa);
            @(posedge clk);
            halted <= 1'b0;
            sl_nr <= 1'b0;
            sl_idle <= 1'b0;
            clear_done();
        end
        $display("test sleep start done");

        // free run chains conversions; first result after the reference switch is dropped
        @(posedge clk);
        ref_sel <= REF_SUPPLY;
        chan <= 5'h02;
        level <= 16'sh0155;
        free_run <= 1'b1;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        wait (done === 1'b1);
        @(posedge clk);
        #1;
        check_flag("free run busy", 1'b1, busy);
        @(posedge clk);
        free_run <= 1'b0;
        clear_done();
        wait_idle();
        check_res(10'h155);
        clear_done();
        $display("test free run done");

        @(posedge clk);
        halted <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check_flag("other sleep power", 1'b1, power);
        check_flag("other sleep idle", 1'b0, busy);
        @(posedge clk);
        en <= 1'b0;
        halted <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check_flag("power off", 1'b0, power);
        $display("test power done");

        // re-enable after sleep so the differential conversion is an extended one
        @(posedge clk);
        en <= 1'b1;
        repeat (2) @(posedge clk);
        convert(t_chan[3], t_lvl[3], t_code[3]);
        clear_done();
        $display("test re-enable done");
        stop_test();
    end
endmodule
`default_nettype wire
